//--- rtl/pic_pkg.sv
// Shared constants and types for the priority interrupt controller.
// Assumes one 20 MHz clock and asynchronous active-low reset.
package pic_pkg;
   localparam int PIC_TRAP_LEVELS  = 8;
   localparam int PIC_GRP_LEVELS   = 24;
   localparam int PIC_BASE_LEVELS  = 16;
   localparam int PIC_EXT_LEVELS   = 48;
   localparam int PIC_ALL_LEVELS   = 56;
   localparam int PIC_IDX_W        = 6;
   // Dedicated word addresses (octal)
   localparam logic [6:0] PIC_VEC_TRAP = 7'o60;
   localparam logic [6:0] PIC_VEC_GRP1 = 7'o70;
   localparam logic [6:0] PIC_VEC_GRP2 = 7'o120;
   // Trap level assignments
   localparam int PIC_TRAP_POWER   = 0;
   localparam int PIC_TRAP_PARITY  = 1;
   localparam int PIC_TRAP_PAGE    = 2;
   localparam int PIC_TRAP_INSTR   = 3;
   localparam int PIC_TRAP_STALL   = 4;
   localparam int PIC_TRAP_TIMER   = 5;
   localparam int PIC_TRAP_FLOAT   = 6;
   localparam int PIC_TRAP_ADDR    = 7;
   // Control word reset values
   localparam logic [23:0] PIC_ARM_RST = 24'h00_0000;
   localparam logic [23:0] PIC_ENA_RST = 24'h00_0000;

   typedef enum logic [1:0] {
      PIC_GRP_TRAP,
      PIC_GRP_ONE,
      PIC_GRP_TWO
   } pic_grp_t;

   // Service request to the processor
   typedef struct packed {
      logic        valid;
      pic_grp_t    grp;
      logic [4:0]  level;
      logic [6:0]  vector;
   } pic_req_t;

   // Per-group control load from the processor
   typedef struct packed {
      logic        ld;
      logic [23:0] arm;
      logic [23:0] ena;
   } pic_ctl_t;
endpackage

//--- rtl/pic_prio_enc.sv
// Fixed-priority encoder, lowest index wins.
// Assumes a purely combinational use inside the controller.
`timescale 1ns/1ps
module pic_prio_enc
   import pic_pkg::*;
#(
   parameter int N = 56,
   parameter int W = 6
) (
   input  wire logic [N-1:0] i_req,
   output logic             o_any,
   output logic [W-1:0]     o_idx
);
   // Refuse an index too narrow to name every input
   if (N > (1 << W)) begin : gen_bad_width
      $error("pic_prio_enc: index too narrow");
   end

   // Scan from the top down so the lowest index is written last and kept
   always_comb begin
      o_any = 1'b0;
      o_idx = '0;
      for (int k = N - 1; k >= 0; k--) begin
         if (i_req[k]) begin
            o_any = 1'b1;
            o_idx = W'(k);
         end
      end
   end
endmodule

//--- rtl/pic_ext_group.sv
// One external interrupt group: arm, enable, waiting, active state.
// Assumes triggers are single-cycle pulses synchronous to I_CLK.
`timescale 1ns/1ps
module pic_ext_group
   import pic_pkg::*;
#(
   parameter int LEVELS = 24
) (
   input  wire logic              i_clk,
   input  wire logic              i_arst_n,
   input  wire logic [LEVELS-1:0] i_trig,
   input  wire logic [LEVELS-1:0] i_soft_req,
   input  wire logic [LEVELS-1:0] i_soft_act,
   input  wire logic              i_ld,
   input  wire logic [LEVELS-1:0] i_arm,
   input  wire logic [LEVELS-1:0] i_ena,
   input  wire logic [LEVELS-1:0] i_grant,
   input  wire logic [LEVELS-1:0] i_done,
   output logic      [LEVELS-1:0] o_wait,
   output logic      [LEVELS-1:0] o_act,
   output logic      [LEVELS-1:0] o_arm,
   output logic      [LEVELS-1:0] o_ena
);
   // A group holds one to twenty-four levels
   if (LEVELS < 1 || LEVELS > PIC_GRP_LEVELS) begin : gen_bad_levels
      $error("pic_ext_group: LEVELS out of range");
   end

   logic [LEVELS-1:0] arm_r, ena_r, wait_r, act_r;
   logic [LEVELS-1:0] wait_nxt, act_nxt;

   // Disarmed levels drop their trigger; a new trigger beats a grant
   assign wait_nxt = (wait_r & ~i_grant) | ((i_trig | i_soft_req) & arm_r);
   assign act_nxt  = (act_r & ~i_done) | i_grant | i_soft_act;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         arm_r  <= '0;
         ena_r  <= '0;
         wait_r <= '0;
         act_r  <= '0;
      end else begin
         if (i_ld) begin
            arm_r <= i_arm;
            ena_r <= i_ena;
         end
         wait_r <= wait_nxt;
         act_r  <= act_nxt;
      end
   end

   assign o_wait = wait_r;
   assign o_act  = act_r;
   assign o_arm  = arm_r;
   assign o_ena  = ena_r;
endmodule

//--- rtl/pic_ctrl.sv
// Priority interrupt controller: eight traps and two external groups.
// Assumes the core pulses instruction-end and return-from-service strobes.
`timescale 1ns/1ps
// Functional notes
// - Levels fall in three groups: traps, external group one, group two.
// - Trap group holds at most eight levels.
// - Up to 48 external levels, 24 per external group.
// - Each level has a unique priority that alone orders service.
// - Priority falls from trap 0 down to group two level 23.
// - Panel indicator lights while any level is active and enabled.
// - Trap levels are tied to fixed internal sources 0 to 7.
// - A recognised level diverts the processor to its service routine.
// - Base has group one 0-15; expansion adds 32 more levels.
// - External source to level mapping is left to the system build.
// - Each level owns a dedicated word at octal 60, 70 or 120 onward.
// - Traps always armed and enabled, activate unless higher level active.
// - Armed level waits on trigger; disarmed level ignores it.
// - Enabled waiting level activates at instruction end if not held.
module pic_ctrl
   import pic_pkg::*;
#(
   parameter bit EXPANSION = 1'b1
) (
   input  wire logic                    I_CLK,
   input  wire logic                    I_ARST_N,
   input  wire logic                    I_TRAP_POWER,
   input  wire logic                    I_TRAP_PARITY,
   input  wire logic                    I_TRAP_PAGE,
   input  wire logic                    I_TRAP_INSTR,
   input  wire logic                    I_TRAP_STALL,
   input  wire logic                    I_TRAP_TIMER,
   input  wire logic                    I_TRAP_FLOAT_ARITH_UNIT,
   input  wire logic                    I_TRAP_ADDR,
   input  wire logic [PIC_EXT_LEVELS-1:0] I_EXT_TRIG,
   input  wire logic [PIC_EXT_LEVELS-1:0] I_SOFT_REQ,
   input  wire logic [PIC_EXT_LEVELS-1:0] I_SOFT_ACT,
   input  wire pic_ctl_t                I_CTL_GRP1,
   input  wire pic_ctl_t                I_CTL_GRP2,
   input  wire logic                    I_INSTR_END,
   input  wire logic                    I_HOLD_SET,
   input  wire logic                    I_HOLD_REL,
   input  wire logic                    I_ACK,
   input  wire logic                    I_SVC_DONE,
   output pic_req_t                     O_REQ,
   output logic [PIC_EXT_LEVELS-1:0]    O_EXT_WAIT,
   output logic [PIC_EXT_LEVELS-1:0]    O_EXT_ACT,
   output logic [PIC_TRAP_LEVELS-1:0]   O_TRAP_ACT,
   output logic                         O_HOLD,
   output logic                         O_PANEL_INT
);
   localparam int G2_OFS = PIC_TRAP_LEVELS + PIC_GRP_LEVELS;

   // Fixed trap wiring; bit position is the trap level
   logic [PIC_TRAP_LEVELS-1:0] trap_trig;
   assign trap_trig[PIC_TRAP_POWER]  = I_TRAP_POWER;
   assign trap_trig[PIC_TRAP_PARITY] = I_TRAP_PARITY;
   assign trap_trig[PIC_TRAP_PAGE]   = I_TRAP_PAGE;
   assign trap_trig[PIC_TRAP_INSTR]  = I_TRAP_INSTR;
   assign trap_trig[PIC_TRAP_STALL]  = I_TRAP_STALL;
   assign trap_trig[PIC_TRAP_TIMER]  = I_TRAP_TIMER;
   assign trap_trig[PIC_TRAP_FLOAT]  = I_TRAP_FLOAT_ARITH_UNIT;
   assign trap_trig[PIC_TRAP_ADDR]   = I_TRAP_ADDR;

   // Levels not fitted are masked; the base board has group one 0-15
   localparam logic [PIC_EXT_LEVELS-1:0] FITTED =
      EXPANSION ? {PIC_EXT_LEVELS{1'b1}}
                : {{(PIC_EXT_LEVELS-PIC_BASE_LEVELS){1'b0}},
                   {PIC_BASE_LEVELS{1'b1}}};

   logic [PIC_TRAP_LEVELS-1:0] trap_wait_r, trap_act_r;
   logic [PIC_EXT_LEVELS-1:0]  ext_wait, ext_act, ext_arm, ext_ena;
   logic [PIC_EXT_LEVELS-1:0]  ext_grant, ext_done;
   logic                       hold_r;
   pic_req_t                   req_r;
   logic [PIC_ALL_LEVELS-1:0]  svc_done;

   // Groups one and two; sources reach levels by board wiring
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_grp
         localparam int B = g * PIC_GRP_LEVELS;
         pic_ext_group #(.LEVELS(PIC_GRP_LEVELS)) u_grp (
            .i_clk      (I_CLK),
            .i_arst_n   (I_ARST_N),
            .i_trig     (I_EXT_TRIG[B +: PIC_GRP_LEVELS]
                         & FITTED[B +: PIC_GRP_LEVELS]),
            .i_soft_req (I_SOFT_REQ[B +: PIC_GRP_LEVELS]
                         & FITTED[B +: PIC_GRP_LEVELS]),
            .i_soft_act (I_SOFT_ACT[B +: PIC_GRP_LEVELS]
                         & FITTED[B +: PIC_GRP_LEVELS]),
            .i_ld       (g == 0 ? I_CTL_GRP1.ld : I_CTL_GRP2.ld),
            .i_arm      ((g == 0 ? I_CTL_GRP1.arm : I_CTL_GRP2.arm)
                         & FITTED[B +: PIC_GRP_LEVELS]),
            .i_ena      (g == 0 ? I_CTL_GRP1.ena : I_CTL_GRP2.ena),
            .i_grant    (ext_grant[B +: PIC_GRP_LEVELS]),
            .i_done     (ext_done[B +: PIC_GRP_LEVELS]),
            .o_wait     (ext_wait[B +: PIC_GRP_LEVELS]),
            .o_act      (ext_act[B +: PIC_GRP_LEVELS]),
            .o_arm      (ext_arm[B +: PIC_GRP_LEVELS]),
            .o_ena      (ext_ena[B +: PIC_GRP_LEVELS])
         );
      end
   endgenerate

   // Priority vector: traps in low bits, then group one, then group two
   logic [PIC_ALL_LEVELS-1:0] act_all, act_online, wait_all;
   assign act_all    = {ext_act, trap_act_r};
   assign act_online = {ext_act & ext_ena, trap_act_r};  // Traps always on
   assign wait_all   = {ext_wait & ext_ena, trap_wait_r};

   logic                 act_any, wait_any;
   logic [PIC_IDX_W-1:0] act_idx, wait_idx;

   pic_prio_enc #(.N(PIC_ALL_LEVELS), .W(PIC_IDX_W)) u_act_enc (
      .i_req (act_online),
      .o_any (act_any),
      .o_idx (act_idx)
   );

   pic_prio_enc #(.N(PIC_ALL_LEVELS), .W(PIC_IDX_W)) u_wait_enc (
      .i_req (wait_all),
      .o_any (wait_any),
      .o_idx (wait_idx)
   );

   // Winner must outrank every on-line active level
   logic outranks, is_trap, ext_ok, grant_now;
   assign outranks  = !act_any || (wait_idx < act_idx);
   assign is_trap   = wait_idx < PIC_IDX_W'(PIC_TRAP_LEVELS);
   // Traps go at once; external waits on instruction end and no hold
   assign ext_ok    = I_INSTR_END && !hold_r;
   assign grant_now = wait_any && outranks && !req_r.valid
                      && (is_trap || ext_ok);

   // One-hot grant of the chosen level
   logic [PIC_ALL_LEVELS-1:0] grant_all;
   assign grant_all = grant_now ? (PIC_ALL_LEVELS'(1) << wait_idx) : '0;
   assign ext_grant = grant_all[PIC_ALL_LEVELS-1:PIC_TRAP_LEVELS];

   // Return from service retires the highest active level
   logic                 top_any;
   logic [PIC_IDX_W-1:0] top_idx;
   pic_prio_enc #(.N(PIC_ALL_LEVELS), .W(PIC_IDX_W)) u_top_enc (
      .i_req (act_all),
      .o_any (top_any),
      .o_idx (top_idx)
   );
   assign svc_done = (I_SVC_DONE && top_any)
                     ? (PIC_ALL_LEVELS'(1) << top_idx) : '0;
   assign ext_done = svc_done[PIC_ALL_LEVELS-1:PIC_TRAP_LEVELS];

   // Map a flat index to group, level and dedicated word
   function automatic pic_req_t pic_decode(input logic [PIC_IDX_W-1:0] idx);
      pic_req_t r;
      logic [PIC_IDX_W-1:0] lvl;
      r = '0;
      r.valid = 1'b1;
      if (idx < PIC_IDX_W'(PIC_TRAP_LEVELS)) begin
         lvl = idx;
         r.grp = PIC_GRP_TRAP;
         r.vector = PIC_VEC_TRAP + 7'(lvl);
      end else if (idx < PIC_IDX_W'(G2_OFS)) begin
         lvl = idx - PIC_IDX_W'(PIC_TRAP_LEVELS);
         r.grp = PIC_GRP_ONE;
         r.vector = PIC_VEC_GRP1 + 7'(lvl);
      end else begin
         lvl = idx - PIC_IDX_W'(G2_OFS);
         r.grp = PIC_GRP_TWO;
         r.vector = PIC_VEC_GRP2 + 7'(lvl);
      end
      r.level = lvl[4:0];
      return r;
   endfunction

   // Trap waiting and active state
   logic [PIC_TRAP_LEVELS-1:0] trap_wait_nxt, trap_act_nxt;
   assign trap_wait_nxt = (trap_wait_r & ~grant_all[PIC_TRAP_LEVELS-1:0])
                          | trap_trig;
   assign trap_act_nxt  = (trap_act_r & ~svc_done[PIC_TRAP_LEVELS-1:0])
                          | grant_all[PIC_TRAP_LEVELS-1:0];

   // Hold of external activation; set has priority over release
   logic hold_nxt;
   assign hold_nxt = I_HOLD_SET | (hold_r & ~I_HOLD_REL);

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         trap_wait_r <= '0;
         trap_act_r  <= '0;
         hold_r      <= 1'b0;
      end else begin
         trap_wait_r <= trap_wait_nxt;
         trap_act_r  <= trap_act_nxt;
         hold_r      <= hold_nxt;
      end
   end

   // Service request held until the core acknowledges the diversion
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         req_r <= '0;
      end else if (grant_now) begin
         req_r <= pic_decode(wait_idx);
      end else if (I_ACK) begin
         req_r <= '0;
      end
   end

   // Panel lamp from registered state, so it never glitches
   logic panel_r;
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         panel_r <= 1'b0;
      end else begin
         panel_r <= |act_online;
      end
   end

   assign O_REQ       = req_r;
   assign O_EXT_WAIT  = ext_wait;
   assign O_EXT_ACT   = ext_act;
   assign O_TRAP_ACT  = trap_act_r;
   assign O_HOLD      = hold_r;
   assign O_PANEL_INT = panel_r;
endmodule

//--- sim/pic_ctrl_assertions.sv
// Concurrent checks on the ports of the interrupt controller top.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps
module pic_ctrl_chk
   import pic_pkg::*;
(
   input wire logic                       I_CLK,
   input wire logic                       I_ARST_N,
   input wire logic                       I_TRAP_POWER,
   input wire logic                       I_ACK,
   input wire pic_req_t                   O_REQ,
   input wire logic [PIC_EXT_LEVELS-1:0]  O_EXT_ACT,
   input wire logic [PIC_TRAP_LEVELS-1:0] O_TRAP_ACT,
   input wire logic                       O_HOLD,
   input wire logic                       O_PANEL_INT
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_ARST_N);
   // Level widened to vector width for offset sums
   wire logic [6:0] lvl_x;
   wire logic       any_act;
   assign lvl_x   = {2'h0, O_REQ.level};
   assign any_act = |{O_TRAP_ACT, O_EXT_ACT};

   chk_vec_trap: assert property (
      O_REQ.valid && O_REQ.grp == PIC_GRP_TRAP |->
      O_REQ.vector == PIC_VEC_TRAP + lvl_x && O_REQ.level < 5'h08)
      else $error("trap vector wrong");
   chk_vec_grp1: assert property (
      O_REQ.valid && O_REQ.grp == PIC_GRP_ONE |->
      O_REQ.vector == PIC_VEC_GRP1 + lvl_x && O_REQ.level < 5'h18)
      else $error("group one vector wrong");
   chk_vec_grp2: assert property (
      O_REQ.valid && O_REQ.grp == PIC_GRP_TWO |->
      O_REQ.vector == PIC_VEC_GRP2 + lvl_x && O_REQ.level < 5'h18)
      else $error("group two vector wrong");
   chk_grp_legal: assert property (
      O_REQ.valid |-> O_REQ.grp != 2'h3)
      else $error("no such group");
   chk_req_stands: assert property (
      O_REQ.valid && !I_ACK |=> O_REQ.valid && $stable(O_REQ))
      else $error("request changed before ack");
   chk_ack_drop: assert property (
      O_REQ.valid && I_ACK |=> !O_REQ.valid)
      else $error("request kept after ack");
   chk_panel_on: assert property (
      (|O_TRAP_ACT) [*2] |-> O_PANEL_INT)
      else $error("panel dark with trap active");
   chk_panel_off: assert property (
      !any_act [*2] |-> !O_PANEL_INT)
      else $error("panel lit with nothing active");
   chk_power_fast: assert property (
      I_TRAP_POWER && !O_TRAP_ACT[0] |-> ##[1:16] O_TRAP_ACT[0])
      else $error("power trap not taken");
   chk_hold_block: assert property (
      O_HOLD [*3] |-> (O_EXT_ACT & ~$past(O_EXT_ACT)) == 48'h0)
      else $error("external level activated under hold");

   // Main scenarios reached
   cov_trap: cover property (O_REQ.valid && O_REQ.grp == PIC_GRP_TRAP);
   cov_grp2: cover property (O_REQ.valid && O_REQ.grp == PIC_GRP_TWO);
   cov_hold: cover property (O_HOLD [*3]);
endmodule

bind pic_ctrl pic_ctrl_chk u_chk (
   .I_CLK, .I_ARST_N, .I_TRAP_POWER, .I_ACK, .O_REQ,
   .O_EXT_ACT, .O_TRAP_ACT, .O_HOLD, .O_PANEL_INT
);

//--- sim/pic_core_model.sv
// Behavioural processor core facing the controller's request port.
// Assumes requests hold until acked; acks promptly or a few cycles late.
`timescale 1ns/1ps
module pic_core_model
   import pic_pkg::*;
(
   input  wire logic     i_clk,
   input  wire logic     i_arst_n,
   input  wire pic_req_t i_req,
   output logic          o_ack,
   output logic          o_svc_done,
   output logic          o_instr_end
);
   int seed = 32'h0000_5a17;
   int n;
   initial begin
      o_ack       = 1'b0;
      o_svc_done  = 1'b0;
      o_instr_end = 1'b0;
   end
   // Instruction ends at random spacing, none during reset
   always @(posedge i_clk) begin
      o_instr_end <= i_arst_n && ({$random(seed)} % 3 == 0);
   end
   // Ack, run the routine a while, then return; never overlaps two
   always begin
      @(posedge i_clk);
      if (i_req.valid === 1'b1) begin
         n = {$random(seed)} % 3;
         repeat (n) @(posedge i_clk);
         o_ack <= 1'b1;
         @(posedge i_clk);
         o_ack <= 1'b0;
         n = 1 + {$random(seed)} % 4;
         repeat (n) @(posedge i_clk);
         o_svc_done <= 1'b1;
         @(posedge i_clk);
         o_svc_done <= 1'b0;
      end
   end
endmodule

//--- sim/tb_top.sv
// Self-checking bench: order and vectors of service requests.
// Assumes the core model acks and retires every request in turn.
`timescale 1ns/1ps
module tb_top;
   import pic_pkg::*;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [7:0]  trap = '0;
   logic [47:0] ext_trig = '0;
   logic [47:0] soft_req = '0;
   logic [47:0] m_arm = '0;
   logic [47:0] m_ena = '0;
   logic [63:0] rnd, rsw;
   pic_ctl_t    ctl1 = '0;
   pic_ctl_t    ctl2 = '0;
   logic        hold_set = 1'b0;
   logic        hold_rel = 1'b0;
   logic        ack, svc_done, instr_end, hold, panel, prev_v;
   pic_req_t    req;
   logic [47:0] ext_wait, ext_act;
   logic [7:0]  trap_act;
   logic [13:0] want;
   int          bad_count = 0, checks = 0, cyc = 0, idx;
   int          seed = 32'h0000_3038;
   int          exp_q[$];

   always #25 clk = ~clk;

   pic_ctrl u_dut (.I_CLK(clk), .I_ARST_N(arst_n),
      .I_TRAP_POWER(trap[0]), .I_TRAP_PARITY(trap[1]),
      .I_TRAP_PAGE(trap[2]), .I_TRAP_INSTR(trap[3]),
      .I_TRAP_STALL(trap[4]), .I_TRAP_TIMER(trap[5]),
      .I_TRAP_FLOAT_ARITH_UNIT(trap[6]), .I_TRAP_ADDR(trap[7]),
      .I_EXT_TRIG(ext_trig), .I_SOFT_REQ(soft_req),
      .I_SOFT_ACT(48'h0), .I_CTL_GRP1(ctl1), .I_CTL_GRP2(ctl2),
      .I_INSTR_END(instr_end), .I_HOLD_SET(hold_set),
      .I_HOLD_REL(hold_rel), .I_ACK(ack), .I_SVC_DONE(svc_done),
      .O_REQ(req), .O_EXT_WAIT(ext_wait), .O_EXT_ACT(ext_act),
      .O_TRAP_ACT(trap_act), .O_HOLD(hold), .O_PANEL_INT(panel));

   pic_core_model u_core (.i_clk(clk), .i_arst_n(arst_n), .i_req(req),
      .o_ack(ack), .o_svc_done(svc_done), .o_instr_end(instr_end));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Arm and enable words for both groups, one load pulse
   task automatic load(input logic [47:0] a, input logic [47:0] e);
      m_arm = a;
      m_ena = e;
      @(posedge clk);
      ctl1 <= '{1'b1, a[23:0], e[23:0]};
      ctl2 <= '{1'b1, a[47:24], e[47:24]};
      @(posedge clk);
      ctl1.ld <= 1'b0;
      ctl2.ld <= 1'b0;
   endtask

   // Fire one trigger cycle; model queues the levels it expects served
   task automatic fire(input logic [55:0] s, input logic [47:0] sw,
                       input bit push);
      for (int i = 0; i < 56; i++)
         if (push && s[i] && (i < 8 || (m_arm[i-8] && m_ena[i-8])))
            exp_q.push_back(i);
      @(posedge clk);
      trap     <= s[7:0];
      ext_trig <= s[55:8] & ~sw;
      soft_req <= s[55:8] & sw;
      @(posedge clk);
      trap     <= '0;
      ext_trig <= '0;
      soft_req <= '0;
   endtask

   // Wait until every expected level has been served and retired
   task automatic drain(input string nm);
      int n;
      n = 0;
      while ((exp_q.size() > 0 || trap_act != 0 || ext_act != 0) &&
             n < 2000) begin
         @(posedge clk);
         n++;
      end
      repeat (4) @(posedge clk);
      check(exp_q.size(), 0);
      $display("test %s done", nm);
   endtask

   // Each new request is compared with the model's next level
   always @(posedge clk) begin
      if (req.valid === 1'b1 && prev_v !== 1'b1) begin
         idx = exp_q.size() > 0 ? exp_q.pop_front() : 99;
         want = {(idx < 8 ? 2'h0 : idx < 32 ? 2'h1 : 2'h2),
                 5'(idx < 8 ? idx : idx < 32 ? idx - 8 : idx - 32),
                 7'(7'h30 + idx)};
         check(req, {1'b1, want});
      end
      prev_v <= req.valid;
   end

   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         $display("Error %0t: run timed out", $time);
         tally_and_finish();
      end
   end

   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      @(negedge clk);
      check({panel, hold, req.valid}, 0);
      for (int i = 0; i < 8; i++) begin
         fire(56'h1 << i, '0, 1);
         drain("trap");
      end
      load('1, '1);
      for (int k = 0; k < 3; k++) begin
         rnd = {$random(seed), $random(seed)};
         rsw = {$random(seed), $random(seed)};
         fire(rnd[55:0], rsw[47:0], 1);
         drain("mixed");
      end
      load(48'h0, '1);
      fire(56'h800, '0, 1);
      @(negedge clk);
      check(ext_wait[3], 0);
      drain("disarmed");
      load('1, 48'h0);
      fire(56'h800, '0, 0);
      repeat (8) @(negedge clk);
      check(ext_wait[3], 1);
      exp_q.push_back(11);
      load('1, '1);
      drain("inhibited");
      @(posedge clk);
      hold_set <= 1'b1;
      @(posedge clk);
      hold_set <= 1'b0;
      fire(56'h1 << 32, '0, 0);
      repeat (10) @(negedge clk);
      check({hold, ext_wait[24]}, 2'h3);
      exp_q.push_back(32);
      @(posedge clk);
      hold_rel <= 1'b1;
      @(posedge clk);
      hold_rel <= 1'b0;
      drain("hold");
      tally_and_finish();
   end
endmodule
